// ### pkg/sls_pkg.sv
// package for the slope line setup block: register selects, fields, resets
package sls_pkg;
	// register select codes on the register write port
	localparam logic [4:0] SEL_SLOPE_BASE = 5'h00; // eight octant words 00..07
	localparam logic [4:0] SEL_NOGO_BASE = 5'h08; // eight setup-only words 08..0f
	localparam logic [4:0] SEL_ADDR = 5'h10;
	localparam logic [4:0] SEL_MASK_DATA = 5'h11;
	localparam logic [4:0] SEL_WIDTH = 5'h12;
	localparam logic [4:0] SEL_STEP_ONE = 5'h13;
	localparam logic [4:0] SEL_STEP_TWO = 5'h14;
	localparam logic [4:0] SEL_STEP_THREE = 5'h15;
	localparam logic [4:0] SEL_CONTINUE = 5'h16;
	localparam logic [4:0] SEL_MODE = 5'h17;
	localparam logic [4:0] SEL_DEPTH = 5'h18;
	localparam logic [4:0] SEL_ROP = 5'h19;
	localparam logic [4:0] SEL_PLANE = 5'h1a;
	localparam logic [4:0] SEL_FORE = 5'h1b;
	localparam logic [4:0] SEL_BACK = 5'h1c;
	// field positions
	localparam int RISE_LSB = 16;
	localparam int CAP_ENDS_BIT = 15;
	localparam int GRID_RULE_BIT = 14;
	localparam int DEPTH_BIT = 0;
	localparam int DST_FMT_LSB = 8;
	localparam int DST_BYTE_LSB = 10;
	// byte steps per pixel
	localparam logic [15:0] DEEP_STEP = 16'h0004;
	localparam logic [15:0] SHALLOW_STEP = 16'h0001;
	// working length after each segment
	localparam logic [4:0] SEG_FULL = 5'h10;
	// reset values
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] PLANE_RESET = 32'hffff_ffff;
	typedef enum {ST_IDLE, ST_SETUP, ST_LOAD, ST_DRAW} sls_state_type;
endpackage

// ### rtl/sls_setup_calc.sv
// combinational slope setup: stepping terms from one slope word
`timescale 1ns/10ps
module sls_setup_calc (
	input wire logic [31:0] slope_word,
	input wire logic [15:0] bitmap_width,
	input wire logic deep,
	input wire logic cap_ends,
	input wire logic grid_rule,
	output logic [15:0] addr_inc_one,
	output logic [15:0] addr_inc_two,
	output logic [15:0] err_inc_one,
	output logic [15:0] err_inc_two,
	output logic [15:0] init_err,
	output logic [3:0] seg_len
);
	logic [15:0] rise;
	logic [15:0] run;
	logic x_major_flag;
	logic run_nz;
	logic rise_nz;
	logic [15:0] dmajor;
	logic [15:0] dminor;
	logic major_nz;
	logic minor_nz;
	logic [15:0] pix_step;
	logic [15:0] amajor;
	logic [15:0] aminor;
	logic round_bit;
	logic [16:0] err_sum;

	// octant sign does not come from the register index; a zero magnitude negates its step
	assign rise = slope_word[31:sls_pkg::RISE_LSB];
	assign run = slope_word[15:0];
	assign pix_step = deep ? sls_pkg::DEEP_STEP : sls_pkg::SHALLOW_STEP;
	assign x_major_flag = (run >= rise);
	assign run_nz = (run != 16'h0000);
	assign rise_nz = (rise != 16'h0000);
	assign dmajor = x_major_flag ? run : rise;
	assign dminor = x_major_flag ? rise : run;
	assign major_nz = x_major_flag ? run_nz : rise_nz;
	assign minor_nz = x_major_flag ? rise_nz : run_nz;
	assign amajor = x_major_flag ? pix_step : bitmap_width;
	assign aminor = x_major_flag ? bitmap_width : pix_step;

	// rounding differs between the strict and traditional environments
	assign round_bit = grid_rule ? (x_major_flag ? rise_nz : ~run_nz) :
		major_nz;
	assign seg_len = 4'(dmajor + {15'h0000, cap_ends});
	assign err_inc_one = dminor;
	assign err_inc_two = 16'(dmajor + ~dminor + 16'h0001);
	// one extra bit keeps the sign for the arithmetic shift
	assign err_sum = 17'({dminor, 1'b0}) + {1'b1, ~dmajor} +
		{16'h0000, round_bit};
	assign init_err = err_sum[16:1];
	assign addr_inc_one = major_nz ? amajor : 16'(~amajor + 16'h0001);
	assign addr_inc_two = 16'((minor_nz ? aminor : 16'(~aminor + 16'h0001)) +
		addr_inc_one);
endmodule // sls_setup_calc

// ### rtl/sls_line_engine.sv
// line engine: slope setup, working set and opaque pixel stepping
// Summary of operation
// - slope octant write computes, stores stepping terms, then draws a segment
// - slope draws take pattern from mask data, start address only after an address write
// - slope word holds rise in upper half and run in lower half
// - pixel byte step is 4 when deep, otherwise 1
// - larger of run and rise is major; address steps follow the axes
// - rounding bit depends on grid rule environment
// - segment length is major plus cap ends, modulo 16
// - error increments are minor and major minus minor
// - initial error is twice minor plus not major plus round, halved
// - address increments are major step and major plus minor step, each axis step negated when its magnitude is zero
// - setup-only writes load terms but draw nothing
// - opaque lines use destination format and byte, ignoring source
// - working error, length and address drive all stepping
// - drawing starts on slope write or continue write with new pattern
// - working length and error reload only after a slope or setup-only write
// - working address reloads only after a start address write
// - after a segment: next pixel address, length 16, next error
// - at most 16 pixels per segment
// - pattern bit one writes foreground, zero writes background
// - each pixel applies raster op and plane mask
// - negative error adds first increments, else adds second address step and subtracts second error step
// - length decrements each pixel; length one or zero ends the segment
`timescale 1ns/10ps
module sls_line_engine (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic [4:0] reg_sel,
	input wire logic [31:0] reg_wdata,
	output logic reg_ready,
	output logic busy,
	output logic pix_wr,
	output logic [31:0] pix_addr,
	output logic [31:0] pix_color,
	output logic [31:0] pix_plane_mask,
	output logic [3:0] pix_rop,
	output logic [1:0] pix_dst_fmt,
	output logic [1:0] pix_dst_byte,
	output logic [31:0] step_params_one,
	output logic [31:0] step_params_two,
	output logic [31:0] step_params_three
);
	sls_pkg::sls_state_type state;
	logic [31:0] slope_word;
	logic [31:0] line_start_address;
	logic [31:0] line_mask_data;
	logic [15:0] bitmap_width;
	logic [31:0] drawing_mode;
	logic [31:0] pixel_depth;
	logic [31:0] raster_op;
	logic [31:0] plane_mask;
	logic [31:0] foreground_color;
	logic [31:0] background_color;
	logic slope_pending;
	logic addr_pending;
	logic draw_req;
	logic [15:0] pattern;
	logic [15:0] calc_ai1;
	logic [15:0] calc_ai2;
	logic [15:0] calc_ei1;
	logic [15:0] calc_ei2;
	logic [15:0] calc_err;
	logic [3:0] calc_len;
	logic [31:0] work_addr;
	logic [15:0] work_err;
	logic [4:0] work_len;
	logic [3:0] pix_idx;
	logic accept;
	logic sel_slope;
	logic sel_nogo;

	// writes are only taken in idle with ready shown, so a host that holds
	// its request until it sees ready is never taken twice
	assign accept = reg_wr && reg_ready && (state == sls_pkg::ST_IDLE);
	assign sel_slope = (reg_sel[4:3] == sls_pkg::SEL_SLOPE_BASE[4:3]);
	assign sel_nogo = (reg_sel[4:3] == sls_pkg::SEL_NOGO_BASE[4:3]);

	sls_setup_calc u_calc (
		.slope_word(slope_word),
		.bitmap_width(bitmap_width),
		.deep(pixel_depth[sls_pkg::DEPTH_BIT]),
		.cap_ends(drawing_mode[sls_pkg::CAP_ENDS_BIT]),
		.grid_rule(drawing_mode[sls_pkg::GRID_RULE_BIT]),
		.addr_inc_one(calc_ai1),
		.addr_inc_two(calc_ai2),
		.err_inc_one(calc_ei1),
		.err_inc_two(calc_ei2),
		.init_err(calc_err),
		.seg_len(calc_len)
	);

	// plain host registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			line_start_address <= sls_pkg::REG_RESET;
			line_mask_data <= sls_pkg::REG_RESET;
			bitmap_width <= sls_pkg::REG_RESET[15:0];
			drawing_mode <= sls_pkg::REG_RESET;
			pixel_depth <= sls_pkg::REG_RESET;
			raster_op <= sls_pkg::REG_RESET;
			plane_mask <= sls_pkg::PLANE_RESET;
			foreground_color <= sls_pkg::REG_RESET;
			background_color <= sls_pkg::REG_RESET;
		end else if (accept) begin
			case (reg_sel)
				sls_pkg::SEL_ADDR: line_start_address <= reg_wdata;
				sls_pkg::SEL_MASK_DATA: line_mask_data <= reg_wdata;
				sls_pkg::SEL_WIDTH: bitmap_width <= reg_wdata[15:0];
				sls_pkg::SEL_MODE: drawing_mode <= reg_wdata;
				sls_pkg::SEL_DEPTH: pixel_depth <= reg_wdata;
				sls_pkg::SEL_ROP: raster_op <= reg_wdata;
				sls_pkg::SEL_PLANE: plane_mask <= reg_wdata;
				sls_pkg::SEL_FORE: foreground_color <= reg_wdata;
				sls_pkg::SEL_BACK: background_color <= reg_wdata;
				default: ;
			endcase
		end
	end

	// slope word capture, shared by drawing and setup-only registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			slope_word <= sls_pkg::REG_RESET;
		end else if (accept && (sel_slope || sel_nogo)) begin
			slope_word <= reg_wdata;
		end
	end

	// stepping parameter registers: direct writes, or loaded by setup
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			step_params_one <= sls_pkg::REG_RESET;
			step_params_two <= sls_pkg::REG_RESET;
			step_params_three <= sls_pkg::REG_RESET;
		end else if (state == sls_pkg::ST_SETUP) begin
			step_params_one <= {calc_ai1, calc_ei1};
			step_params_two <= {calc_ai2, calc_ei2};
			step_params_three <= {calc_err, 12'h000, calc_len};
		end else if (accept && reg_sel == sls_pkg::SEL_STEP_ONE) begin
			step_params_one <= reg_wdata;
		end else if (accept && reg_sel == sls_pkg::SEL_STEP_TWO) begin
			step_params_two <= reg_wdata;
		end else if (accept && reg_sel == sls_pkg::SEL_STEP_THREE) begin
			step_params_three <= reg_wdata;
		end
	end

	// reload flags: set by writes, consumed when a segment loads
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			slope_pending <= 1'b0;
			addr_pending <= 1'b0;
		end else begin
			if (accept && (sel_slope || sel_nogo)) begin
				slope_pending <= 1'b1;
			end else if (state == sls_pkg::ST_LOAD) begin
				slope_pending <= 1'b0;
			end
			if (accept && reg_sel == sls_pkg::SEL_ADDR) begin
				addr_pending <= 1'b1;
			end else if (state == sls_pkg::ST_LOAD) begin
				addr_pending <= 1'b0;
			end
		end
	end

	// sequencer: setup, optional draw, back to idle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= sls_pkg::ST_IDLE;
			draw_req <= 1'b0;
			pattern <= 16'h0000;
		end else begin
			case (state)
				sls_pkg::ST_IDLE: begin
					if (accept && sel_slope) begin
						draw_req <= 1'b1;
						pattern <= line_mask_data[15:0];
						state <= sls_pkg::ST_SETUP;
					end else if (accept && sel_nogo) begin
						draw_req <= 1'b0;
						state <= sls_pkg::ST_SETUP;
					end else if (accept && reg_sel == sls_pkg::SEL_CONTINUE) begin
						pattern <= reg_wdata[15:0];
						state <= sls_pkg::ST_LOAD;
					end
				end
				sls_pkg::ST_SETUP: begin
					state <= draw_req ? sls_pkg::ST_LOAD : sls_pkg::ST_IDLE;
				end
				sls_pkg::ST_LOAD: begin
					state <= sls_pkg::ST_DRAW;
				end
				sls_pkg::ST_DRAW: begin
					if (work_len == 5'h00 || work_len == 5'h01) begin
						state <= sls_pkg::ST_IDLE;
					end
				end
				default: state <= sls_pkg::ST_IDLE;
			endcase
		end
	end

	// working set: conditional reload, then bresenham stepping
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			work_addr <= sls_pkg::REG_RESET;
			work_err <= 16'h0000;
			work_len <= 5'h00;
			pix_idx <= 4'h0;
		end else if (state == sls_pkg::ST_LOAD) begin
			pix_idx <= 4'h0;
			if (slope_pending) begin
				// length and error come from the stored setup terms
				work_len <= {1'b0, step_params_three[3:0]};
				work_err <= step_params_three[31:16];
			end
			if (addr_pending) begin
				work_addr <= line_start_address;
			end
		end else if (state == sls_pkg::ST_DRAW) begin
			if (work_len != 5'h00) begin
				pix_idx <= 4'(pix_idx + 4'h1);
				if (work_err[15]) begin
					work_addr <= 32'(work_addr +
						{{16{step_params_one[31]}}, step_params_one[31:16]});
					work_err <= 16'(work_err + step_params_one[15:0]);
				end else begin
					work_addr <= 32'(work_addr +
						{{16{step_params_two[31]}}, step_params_two[31:16]});
					work_err <= 16'(work_err - step_params_two[15:0]);
				end
			end
			// a zero length segment also leaves 16 for the next one
			if (work_len == 5'h00 || work_len == 5'h01) begin
				work_len <= sls_pkg::SEG_FULL;
			end else begin
				work_len <= 5'(work_len - 5'h01);
			end
		end
	end

	// pixel write port: one pixel per cycle while length remains
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pix_wr <= 1'b0;
			pix_addr <= sls_pkg::REG_RESET;
			pix_color <= sls_pkg::REG_RESET;
			pix_plane_mask <= sls_pkg::REG_RESET;
			pix_rop <= 4'h0;
			pix_dst_fmt <= 2'h0;
			pix_dst_byte <= 2'h0;
		end else begin
			pix_wr <= (state == sls_pkg::ST_DRAW) && (work_len != 5'h00);
			pix_addr <= work_addr;
			pix_color <= pattern[pix_idx] ? foreground_color :
				background_color;
			pix_plane_mask <= plane_mask;
			pix_rop <= raster_op[3:0];
			pix_dst_fmt <= raster_op[sls_pkg::DST_FMT_LSB +: 2];
			pix_dst_byte <= raster_op[sls_pkg::DST_BYTE_LSB +: 2];
		end
	end

	// handshake outputs, registered
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_ready <= 1'b0;
			busy <= 1'b0;
		end else begin
			reg_ready <= (state == sls_pkg::ST_IDLE) && !accept;
			busy <= (state != sls_pkg::ST_IDLE) || accept;
		end
	end
endmodule // sls_line_engine

// ### sim/sls_line_engine_sva.sv
// port checker for the slope line setup engine
`timescale 1ns/10ps
module sls_line_engine_sva (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic [4:0] reg_sel,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_ready,
	input wire logic busy,
	input wire logic pix_wr,
	input wire logic [31:0] step_params_one,
	input wire logic [31:0] step_params_two,
	input wire logic [31:0] step_params_three
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic cap, grid, pend, xm, rnd;
	logic [3:0] plen;
	logic [4:0] cnt, exp_n;
	logic [15:0] maj, mnr, sum;
	wire tk = reg_wr && reg_ready;
	wire sl = tk && reg_sel[4:3] == 2'b00;
	wire ng = tk && reg_sel[4:3] == 2'b01;
	wire ct = tk && reg_sel == sls_pkg::SEL_CONTINUE;
	wire [4:0] cexp = pend ? {1'b0, plen} : sls_pkg::SEG_FULL;
	// shadow setup arithmetic on the word being written
	always_comb begin
		xm = reg_wdata[15:0] >= reg_wdata[31:16];
		maj = xm ? reg_wdata[15:0] : reg_wdata[31:16];
		mnr = xm ? reg_wdata[31:16] : reg_wdata[15:0];
		rnd = grid ? (xm ? reg_wdata[31:16] != 0 : reg_wdata[15:0] == 0) : maj != 0;
		sum = (mnr << 1) + ~maj + {15'h0, rnd};
	end
	wire [3:0] len = maj[3:0] + {3'h0, cap};
	wire [15:0] e2 = maj - mnr;
	wire [15:0] ie = {sum[15], sum[15:1]};
	// mode bits and a pending setup-only length, since continue reloads it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{cap, grid, pend, plen} <= 7'h00;
		end else begin
			if (tk && reg_sel == sls_pkg::SEL_MODE) begin
				cap <= reg_wdata[sls_pkg::CAP_ENDS_BIT];
				grid <= reg_wdata[sls_pkg::GRID_RULE_BIT];
			end
			if (ng) plen <= len;
			pend <= ng ? 1'b1 : (sl || ct) ? 1'b0 : pend;
		end
	end
	// pixels since the last take against the length expected
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{cnt, exp_n} <= 10'h000;
		end else begin
			cnt <= tk ? 5'h00 : cnt + {4'h0, pix_wr};
			if (sl) exp_n <= {1'b0, len};
			else if (ct) exp_n <= cexp;
		end
	end
	chk_take_busy: assert property (tk |=> busy)
		else $error("busy low after a taken write");
	chk_slope_first: assert property (
		sl && len != 0 |-> ##1 !pix_wr [*3] ##1 pix_wr)
		else $error("slope pixel not on fourth edge");
	chk_cont_first: assert property (
		ct && cexp != 0 |-> ##1 !pix_wr [*2] ##1 pix_wr)
		else $error("continue pixel not on third edge");
	chk_setup_quiet: assert property (ng |-> ##1 !pix_wr [*4])
		else $error("setup-only write drew a pixel");
	chk_seg_count: assert property ($fell(pix_wr) |-> cnt == exp_n)
		else $error("segment pixel count wrong");
	chk_len_field: assert property (
		sl || ng |-> ##2 step_params_three[3:0] == $past(len, 2))
		else $error("length field wrong");
	chk_err_incs: assert property (
		sl || ng |-> ##2 step_params_one[15:0] == $past(mnr, 2)
		&& step_params_two[15:0] == $past(e2, 2))
		else $error("error increments wrong");
	chk_init_err: assert property (
		sl || ng |-> ##2 step_params_three[31:16] == $past(ie, 2))
		else $error("initial error wrong");
endmodule // sls_line_engine_sva

// ### sim/sls_host.sv
// host model: register writes as the processor makes them
`timescale 1ns/10ps
module sls_host (
	input wire logic ref_clk,
	input wire logic reg_ready,
	output logic reg_wr,
	output logic [4:0] reg_sel,
	output logic [31:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_sel = 5'h00;
		reg_wdata = 32'h00000000;
	end
	// one write, held until an edge that finds ready high
	task automatic wr(input logic [4:0] sel, input logic [31:0] data);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_sel <= sel;
		reg_wdata <= data;
		do @(posedge ref_clk); while (reg_ready !== 1'b1);
		reg_wr <= 1'b0;
		reg_sel <= ~sel; // released lines carry junk, not the old value
		reg_wdata <= ~data;
	endtask
	// a zero slope has no defined setup, so it is never sent
	task automatic slope(input logic [4:0] sel, input logic [31:0] word);
		if (word != 32'h00000000) wr(sel, word);
	endtask
endmodule // sls_host

// ### sim/test_sls_line_engine.sv
// testbench for the slope line setup engine
`timescale 1ns/10ps
module test_sls_line_engine;
	logic ref_clk, resetn, reg_wr, reg_ready, busy, pix_wr;
	logic [4:0] reg_sel;
	logic [31:0] reg_wdata, pix_addr, pix_color, pix_plane_mask, sp1, sp2, sp3;
	logic [3:0] pix_rop;
	logic [1:0] pix_dst_fmt, pix_dst_byte;
	int bad_count, compares, cyc;
	logic [31:0] qa[$], qc[$], fg, bg, wa, a1, a2;
	logic [15:0] e1, e2, we;
	sls_line_engine sls_line_engine_i (.ref_clk(ref_clk), .resetn(resetn),
		.reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
		.reg_ready(reg_ready), .busy(busy), .pix_wr(pix_wr),
		.pix_addr(pix_addr), .pix_color(pix_color), .pix_rop(pix_rop),
		.pix_plane_mask(pix_plane_mask), .pix_dst_fmt(pix_dst_fmt),
		.pix_dst_byte(pix_dst_byte), .step_params_one(sp1),
		.step_params_two(sp2), .step_params_three(sp3));
	sls_host sls_host_i (.ref_clk(ref_clk), .reg_ready(reg_ready),
		.reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata));
	task automatic cmp(input logic [31:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s: %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic w(input logic [4:0] s, input logic [31:0] d);
		sls_host_i.wr(s, d);
	endtask
	// clock and a cycle ceiling well past the whole run
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// gather pixels; raster fields stay fixed for every drawing
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			wrap_up;
		end
		if (pix_wr === 1'b1) begin
			qa.push_back(pix_addr);
			qc.push_back(pix_color);
			cmp(pix_plane_mask, 32'h00ff00ff, "plane mask");
			cmp({20'h0, pix_dst_byte, pix_dst_fmt, 4'h0, pix_rop}, 32'h00000e06,
				"raster fields");
		end
	end
	// let the segment run out; ready returns once idle
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		for (int k = 0; k < 60 && reg_ready !== 1'b1; k++) @(posedge ref_clk);
		@(posedge ref_clk);
	endtask
	// step a reference line and compare each pixel the engine wrote
	task automatic chk_seg(input int n, input logic [15:0] mask);
		cmp(qa.size(), n, "pixel count");
		for (int i = 0; i < n && qa.size() > 0; i++) begin
			cmp(qa.pop_front(), wa, "pixel address");
			cmp(qc.pop_front(), mask[i] ? fg : bg, "pixel colour");
			if (we[15]) begin
				wa = wa + a1;
				we = we + e1;
			end else begin
				wa = wa + a2;
				we = we - e2;
			end
		end
		qa.delete();
		qc.delete();
	endtask
	// setup-only words through all eight selects, no pixels drawn
	task automatic t_setup;
		logic [31:0] tab [4][5] = '{
			'{32'h0, 32'h00020005, 32'h00010002, 32'h01010003, 32'hffff0005},
			'{32'h8000, 32'h00070003, 32'h01000003, 32'h01040004, 32'hffff0008},
			'{32'h4000, 32'h00000004, 32'h00010000, 32'hff010004, 32'hfffd0004},
			'{32'h4000, 32'h00030000, 32'h01000000, 32'h00fc0003, 32'hfffe0003}};
		w(sls_pkg::SEL_WIDTH, 32'h00000100);
		for (int i = 0; i < 8; i++) begin
			w(sls_pkg::SEL_MODE, tab[i%4][0]);
			w(sls_pkg::SEL_DEPTH, {31'h0, i[0]});
			sls_host_i.slope(sls_pkg::SEL_NOGO_BASE + 5'(i), tab[i%4][1]);
			settle;
			cmp(sp1, tab[i%4][2], "steps one");
			cmp(sp2, tab[i%4][3], "steps two");
			cmp(sp3, tab[i%4][4], "steps three");
		end
		cmp(qa.size(), 0, "setup pixels");
	endtask
	// a slope draw, a write held off meanwhile, then an extension
	task automatic t_draw;
		fg = 32'h00aa00aa;
		bg = 32'h00550055;
		w(sls_pkg::SEL_DEPTH, 32'h0);
		w(sls_pkg::SEL_MODE, 32'h00008000);
		w(sls_pkg::SEL_ROP, 32'h00000e06);
		w(sls_pkg::SEL_PLANE, 32'h00ff00ff);
		w(sls_pkg::SEL_FORE, fg);
		w(sls_pkg::SEL_BACK, bg);
		w(sls_pkg::SEL_ADDR, 32'h00001000);
		w(sls_pkg::SEL_MASK_DATA, 32'hffff0005);
		sls_host_i.slope(sls_pkg::SEL_SLOPE_BASE, 32'h00010003);
		w(sls_pkg::SEL_FORE, 32'h00cc00cc);
		settle;
		{wa, we, a1, a2, e1, e2} = {32'h1000, 16'hffff, 32'h1, 32'h101,
			16'h1, 16'h2};
		chk_seg(4, 16'h0005);
		fg = 32'h00cc00cc;
		w(sls_pkg::SEL_MODE, 32'h0);
		w(sls_pkg::SEL_CONTINUE, 32'h0000ffff);
		settle;
		chk_seg(16, 16'hffff);
	endtask
	// polyline keeps the address; a new address keeps the error
	task automatic t_link;
		w(sls_pkg::SEL_MASK_DATA, 32'h00000002);
		{a1, a2, e1, e2} = {32'h1, 32'hffffff01, 16'h0, 16'h2};
		for (int o = 1; o < 8; o++) begin
			sls_host_i.slope(sls_pkg::SEL_SLOPE_BASE + 5'(o), 32'h00000002);
			settle;
			we = 16'hffff;
			chk_seg(2, 16'h0002);
		end
		wa = 32'h00002000;
		w(sls_pkg::SEL_ADDR, wa);
		w(sls_pkg::SEL_CONTINUE, 32'h000000f0);
		settle;
		chk_seg(16, 16'h00f0);
	endtask
	initial begin
		resetn = 1'b0;
		{bad_count, compares, cyc} = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_setup;
		t_draw;
		t_link;
		wrap_up;
	end
endmodule // test_sls_line_engine
bind sls_line_engine sls_line_engine_sva sls_line_engine_sva_i (
	.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_sel(reg_sel),
	.reg_wdata(reg_wdata), .reg_ready(reg_ready), .busy(busy),
	.pix_wr(pix_wr), .step_params_one(step_params_one),
	.step_params_two(step_params_two), .step_params_three(step_params_three));
